// ### hw/ummu_defines.svh
`ifndef UMMU_DEFINES_SVH
`define UMMU_DEFINES_SVH
`define UMMU_W        16
`define UMMU_MSB      15
`define UMMU_PMSB     31
`define UMMU_ZERO16   16'h0000
`define UMMU_ZERO32   32'h0000_0000
`define UMMU_FLG_C    0
`define UMMU_FLG_V    1
`define UMMU_FLG_Z    2
`define UMMU_FLG_N    3
`define UMMU_FLG_I    4
`define UMMU_FLG_H    5
`define UMMU_FLG_X    6
`define UMMU_FLG_S    7
`define UMMU_FLAGS_RST 8'hD0
`endif

// ### hw/ummu_pkg.sv
`default_nettype none
package ummu_pkg;
  typedef enum logic [2:0] {
    UMMU_OP_MAXA = 3'h0,
    UMMU_OP_MAXM = 3'h1,
    UMMU_OP_MINA = 3'h2,
    UMMU_OP_MINM = 3'h3,
    UMMU_OP_MUL  = 3'h4
  } ummu_op_type;
  typedef enum logic [2:0] {
    UMMU_ST_IDLE  = 3'b001,
    UMMU_ST_READ  = 3'b010,
    UMMU_ST_WRITE = 3'b100
  } ummu_state_type;
endpackage
`default_nettype wire

// ### hw/ummu_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "ummu_defines.svh"

module ummu_unit
  import ummu_pkg::*;
(
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST_B,
  // instruction request
  input  wire logic                 START,
  input  wire logic [2:0]           OPCODE,
  input  wire logic [`UMMU_W-1:0]   INDEXED_ADDR,
  output logic                      BUSY,
  output logic                      DONE,
  // register file
  input  wire logic                 REG_LOAD,
  input  wire logic [`UMMU_W-1:0]   ACC_IN,
  input  wire logic [`UMMU_W-1:0]   Y_IN,
  input  wire logic [7:0]           FLAGS_IN,
  output logic [`UMMU_W-1:0]        ACC_OUT,
  output logic [`UMMU_W-1:0]        Y_OUT,
  output logic [7:0]                CONDITION_FLAGS,
  // memory bus
  output logic                      MEM_RD,
  output logic                      MEM_WR,
  output logic [`UMMU_W-1:0]        MEM_ADDR,
  output logic [`UMMU_W-1:0]        MEM_WDATA,
  input  wire logic [`UMMU_W-1:0]   MEM_RDATA,
  input  wire logic                 MEM_ACK
);

  logic                rst_s1_q;
  logic                rst_b_q;
  ummu_state_type      state_q;
  ummu_op_type         op_q;
  logic [`UMMU_W-1:0]  acc_q;
  logic [`UMMU_W-1:0]  y_q;
  logic [7:0]          flags_q;
  logic [`UMMU_W-1:0]  addr_q;
  logic [`UMMU_W-1:0]  wdata_q;
  logic                done_q;
  logic [`UMMU_W-1:0]  diff;
  logic                borrow;
  logic                ovf;
  logic [`UMMU_W-1:0]  sel_val;
  logic                want_max;
  logic [31:0]         prod;
  logic signed [`UMMU_W:0] ref_sdiff;
  logic                ref_n;
  logic                ref_v;

  // reset asserts at once and is released through two flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_q <= 1'b0;
      rst_b_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_b_q  <= rst_s1_q;
    end
  end

  // compare datapath: acc minus memory word
  always_comb begin
    diff     = acc_q - MEM_RDATA;
    borrow   = (~acc_q[`UMMU_MSB] & MEM_RDATA[`UMMU_MSB])
             | (MEM_RDATA[`UMMU_MSB] & diff[`UMMU_MSB])
             | (diff[`UMMU_MSB] & ~acc_q[`UMMU_MSB]);
    ovf      = (acc_q[`UMMU_MSB] & ~MEM_RDATA[`UMMU_MSB] & ~diff[`UMMU_MSB])
             | (~acc_q[`UMMU_MSB] & MEM_RDATA[`UMMU_MSB] & diff[`UMMU_MSB]);
    want_max = (op_q == UMMU_OP_MAXA) || (op_q == UMMU_OP_MAXM);
    if (want_max) begin
      sel_val = borrow ? MEM_RDATA : acc_q;
    end else begin
      sel_val = borrow ? acc_q : MEM_RDATA;
    end
  end

  assign prod = {`UMMU_ZERO16, acc_q} * {`UMMU_ZERO16, y_q};

  // sequencing: operand read, write-back for memory forms, done pulse
  always_ff @(posedge CLK or negedge rst_b_q) begin
    if (!rst_b_q) begin
      state_q <= UMMU_ST_IDLE;
      op_q    <= UMMU_OP_MAXA;
      addr_q  <= `UMMU_ZERO16;
      wdata_q <= `UMMU_ZERO16;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        UMMU_ST_IDLE: begin
          if (START && (OPCODE <= UMMU_OP_MUL)) begin
            op_q   <= ummu_op_type'(OPCODE);
            addr_q <= INDEXED_ADDR;
            // the multiply needs no bus cycle and ends at once
            if (OPCODE == UMMU_OP_MUL) begin
              done_q <= 1'b1;
            end else begin
              state_q <= UMMU_ST_READ;
            end
          end
        end
        UMMU_ST_READ: begin
          if (MEM_ACK) begin
            wdata_q <= sel_val;
            if ((op_q == UMMU_OP_MAXM) || (op_q == UMMU_OP_MINM)) begin
              state_q <= UMMU_ST_WRITE;
            end else begin
              state_q <= UMMU_ST_IDLE;
              done_q  <= 1'b1;
            end
          end
        end
        UMMU_ST_WRITE: begin
          if (MEM_ACK) begin
            state_q <= UMMU_ST_IDLE;
            done_q  <= 1'b1;
          end
        end
        default: state_q <= UMMU_ST_IDLE;
      endcase
    end
  end

  // register file and flag updates
  always_ff @(posedge CLK or negedge rst_b_q) begin
    if (!rst_b_q) begin
      acc_q   <= `UMMU_ZERO16;
      y_q     <= `UMMU_ZERO16;
      flags_q <= `UMMU_FLAGS_RST;
    end else if (REG_LOAD && (state_q == UMMU_ST_IDLE) && !START) begin
      acc_q   <= ACC_IN;
      y_q     <= Y_IN;
      flags_q <= FLAGS_IN;
    end else if ((state_q == UMMU_ST_IDLE) && START && (OPCODE == UMMU_OP_MUL)) begin
      y_q <= prod[`UMMU_PMSB:`UMMU_W];
      acc_q <= prod[`UMMU_MSB:0];
      flags_q[`UMMU_FLG_C] <= prod[`UMMU_MSB];
      flags_q[`UMMU_FLG_N] <= prod[`UMMU_PMSB];
      flags_q[`UMMU_FLG_Z] <= (prod == `UMMU_ZERO32);
    end else if ((state_q == UMMU_ST_READ) && MEM_ACK) begin
      if ((op_q == UMMU_OP_MAXA) || (op_q == UMMU_OP_MINA)) begin
        acc_q <= sel_val;
      end
      flags_q[`UMMU_FLG_C] <= borrow;
      flags_q[`UMMU_FLG_V] <= ovf;
      flags_q[`UMMU_FLG_Z] <= (diff == `UMMU_ZERO16);
      flags_q[`UMMU_FLG_N] <= diff[`UMMU_MSB];
    end
  end

  // upper four flag bits are never written by an operation
  assign BUSY            = (state_q != UMMU_ST_IDLE);
  assign DONE            = done_q;
  assign ACC_OUT         = acc_q;
  assign Y_OUT           = y_q;
  assign CONDITION_FLAGS = flags_q;
  assign MEM_RD          = (state_q == UMMU_ST_READ);
  assign MEM_WR          = (state_q == UMMU_ST_WRITE);
  assign MEM_ADDR        = addr_q;
  assign MEM_WDATA       = wdata_q;

  // independent signed reference for the compare N and V flag checks
  assign ref_sdiff = $signed({ACC_OUT[`UMMU_MSB], ACC_OUT})
                   - $signed({MEM_RDATA[`UMMU_MSB], MEM_RDATA});
  assign ref_n     = ref_sdiff[`UMMU_MSB];
  assign ref_v     = ref_sdiff[`UMMU_W] ^ ref_sdiff[`UMMU_MSB];

  AST_MUL_RESULT: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (state_q == UMMU_ST_IDLE && START && OPCODE == UMMU_OP_MUL)
    |=> ({Y_OUT, ACC_OUT} == $past(ACC_OUT) * $past(Y_OUT)) && DONE)
    else $error("multiply result wrong");
  AST_MUL_C: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (state_q == UMMU_ST_IDLE && START && OPCODE == UMMU_OP_MUL)
    |=> CONDITION_FLAGS[`UMMU_FLG_C] == ACC_OUT[`UMMU_MSB])
    else $error("multiply carry wrong");
  AST_MUL_NZ: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (state_q == UMMU_ST_IDLE && START && OPCODE == UMMU_OP_MUL)
    |=> CONDITION_FLAGS[`UMMU_FLG_N] == Y_OUT[`UMMU_MSB]
        && CONDITION_FLAGS[`UMMU_FLG_Z] == ({Y_OUT, ACC_OUT} == `UMMU_ZERO32))
    else $error("multiply n or z wrong");
  AST_MUL_KEEP_V: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (state_q == UMMU_ST_IDLE && START && OPCODE == UMMU_OP_MUL)
    |=> $stable(CONDITION_FLAGS[`UMMU_FLG_V]))
    else $error("multiply changed overflow");
  AST_UPPER_KEEP: assert property (@(posedge CLK) disable iff (!rst_b_q)
    !(REG_LOAD && state_q == UMMU_ST_IDLE && !START)
    |=> $stable(CONDITION_FLAGS[`UMMU_FLG_S:`UMMU_FLG_I]))
    else $error("upper flags changed");

  AST_CMP_Z: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && MEM_ACK)
    |=> CONDITION_FLAGS[`UMMU_FLG_Z] == ($past(ACC_OUT) == $past(MEM_RDATA)))
    else $error("zero flag wrong");
  AST_CMP_C: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && MEM_ACK)
    |=> CONDITION_FLAGS[`UMMU_FLG_C] == ($past(MEM_RDATA) > $past(ACC_OUT)))
    else $error("carry flag wrong");
  AST_CMP_NV: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && MEM_ACK)
    |=> CONDITION_FLAGS[`UMMU_FLG_N] == $past(ref_n)
        && CONDITION_FLAGS[`UMMU_FLG_V] == $past(ref_v))
    else $error("n or v flag wrong");
  AST_ACC_MAX: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && MEM_ACK && op_q == UMMU_OP_MAXA)
    |=> ACC_OUT == (($past(MEM_RDATA) > $past(ACC_OUT)) ? $past(MEM_RDATA) : $past(ACC_OUT)))
    else $error("max to accumulator wrong");
  AST_ACC_MIN: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && MEM_ACK && op_q == UMMU_OP_MINA)
    |=> ACC_OUT == (($past(MEM_RDATA) < $past(ACC_OUT)) ? $past(MEM_RDATA) : $past(ACC_OUT)))
    else $error("min to accumulator wrong");
  AST_MEM_WB: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && MEM_ACK && (op_q == UMMU_OP_MAXM || op_q == UMMU_OP_MINM))
    |=> MEM_WR && MEM_ADDR == $past(MEM_ADDR) && ACC_OUT == $past(ACC_OUT))
    else $error("no write-back");
  AST_MEM_SEL: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && MEM_ACK && op_q == UMMU_OP_MAXM)
    |=> MEM_WDATA == (($past(MEM_RDATA) > ACC_OUT) ? $past(MEM_RDATA) : ACC_OUT))
    else $error("max to memory wrong");
  AST_MEM_MIN: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && MEM_ACK && op_q == UMMU_OP_MINM)
    |=> MEM_WDATA == (($past(MEM_RDATA) < ACC_OUT) ? $past(MEM_RDATA) : ACC_OUT))
    else $error("min to memory wrong");
  AST_ADDR_HELD: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (BUSY && $past(BUSY)) |-> $stable(MEM_ADDR))
    else $error("address moved mid operation");

  // bus handshake: each request holds until acknowledged
  AST_FETCH_ADDR: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (!BUSY && START && OPCODE < UMMU_OP_MUL)
    |=> MEM_RD && !MEM_WR && MEM_ADDR == $past(INDEXED_ADDR))
    else $error("operand fetch not at indexed address");
  AST_REFUSE_BUSY: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (BUSY && START)
    |=> $stable(MEM_ADDR))
    else $error("request taken while busy");
  AST_RD_HOLD: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && !MEM_ACK)
    |=> MEM_RD && $stable(MEM_ADDR))
    else $error("read dropped before acknowledge");
  AST_WR_HOLD: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_WR && !MEM_ACK)
    |=> MEM_WR && $stable(MEM_ADDR) && $stable(MEM_WDATA))
    else $error("write dropped before acknowledge");
  AST_WB_DONE: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_WR && MEM_ACK)
    |=> DONE && !BUSY)
    else $error("write-back did not complete");
  AST_ACC_DONE: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && MEM_ACK && (op_q == UMMU_OP_MAXA || op_q == UMMU_OP_MINA))
    |=> DONE && !BUSY && !MEM_WR)
    else $error("accumulator compare did not complete");
  AST_MUL_NO_BUS: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (!BUSY && START && OPCODE == UMMU_OP_MUL)
    |=> !BUSY && !MEM_RD && !MEM_WR)
    else $error("multiply used the bus");
  AST_BAD_OP: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (!BUSY && START && OPCODE > UMMU_OP_MUL)
    |=> !BUSY && !DONE && $stable(CONDITION_FLAGS) && $stable(ACC_OUT) && $stable(Y_OUT))
    else $error("undefined operation code acted on");
  AST_BUSY_KEEP: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (BUSY && !(MEM_RD && MEM_ACK))
    |=> $stable(ACC_OUT) && $stable(Y_OUT))
    else $error("registers changed while busy");
  AST_CMP_Y_KEEP: assert property (@(posedge CLK) disable iff (!rst_b_q)
    (MEM_RD && MEM_ACK)
    |=> $stable(Y_OUT) && $stable(CONDITION_FLAGS[`UMMU_FLG_S:`UMMU_FLG_I]))
    else $error("compare changed y or upper flags");

  COV_MUL: cover property (@(posedge CLK) disable iff (!rst_b_q)
    state_q == UMMU_ST_IDLE && START && OPCODE == UMMU_OP_MUL);
  COV_MAXA: cover property (@(posedge CLK) disable iff (!rst_b_q)
    MEM_RD && MEM_ACK && op_q == UMMU_OP_MAXA && borrow);
  COV_MINM_WB: cover property (@(posedge CLK) disable iff (!rst_b_q)
    MEM_WR && MEM_ACK && op_q == UMMU_OP_MINM);
  COV_EQUAL: cover property (@(posedge CLK) disable iff (!rst_b_q)
    MEM_RD && MEM_ACK && diff == `UMMU_ZERO16);
  COV_MAXM_WB: cover property (@(posedge CLK) disable iff (!rst_b_q)
    MEM_WR && MEM_ACK && op_q == UMMU_OP_MAXM);

endmodule
`default_nettype wire

// ### sim/ummu_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ummu_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // memory bus
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  dly,
  output logic [15:0]      rdata,
  output logic             ack
);
  logic [15:0] mem [16];
  logic [1:0]  cnt;
  int          n_wr = 0;
  // acks after dly waits; read data scrambles outside the ack cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
      cnt <= 2'h0;
      rdata <= 16'h5A5A;
    end else if (ack) begin
      ack <= 1'b0;
      cnt <= 2'h0;
      rdata <= ~rdata;
      if (wr) begin
        mem[addr[3:0]] <= wdata;
        n_wr <= n_wr + 1;
      end
    end else if ((rd || wr) && cnt == dly) begin
      ack <= 1'b1;
      rdata <= rd ? mem[addr[3:0]] : ~rdata;
    end else begin
      rdata <= ~rdata;
      if (rd || wr) cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### sim/ummu_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ummu_unit_tb;
  import ummu_pkg::*;
  logic        CLK, RST_B, START, REG_LOAD, MEM_ACK, BUSY, DONE, MEM_RD, MEM_WR;
  logic [2:0]  OPCODE;
  logic [15:0] INDEXED_ADDR, ACC_IN, Y_IN, ACC_OUT, Y_OUT, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic [7:0]  FLAGS_IN, CONDITION_FLAGS, f;
  logic [1:0]  dly;
  logic [15:0] a, m, d, res;
  logic [31:0] p;
  logic [15:0] av [4] = '{16'h1234, 16'h0001, 16'h8000, 16'h7FFF};
  logic [15:0] mv [4] = '{16'h1234, 16'hFFFF, 16'h7FFF, 16'h8000};
  int          err_total, n_checks, i, w0;
  ummu_unit ummu_unit_i (.CLK(CLK), .RST_B(RST_B), .START(START), .OPCODE(OPCODE),
    .INDEXED_ADDR(INDEXED_ADDR), .BUSY(BUSY), .DONE(DONE), .REG_LOAD(REG_LOAD),
    .ACC_IN(ACC_IN), .Y_IN(Y_IN), .FLAGS_IN(FLAGS_IN), .ACC_OUT(ACC_OUT), .Y_OUT(Y_OUT),
    .CONDITION_FLAGS(CONDITION_FLAGS), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK));
  ummu_mem_model ummu_mem_model_i (.clk(CLK), .rst_b(RST_B), .rd(MEM_RD), .wr(MEM_WR),
    .addr(MEM_ADDR), .wdata(MEM_WDATA), .dly(dly), .rdata(MEM_RDATA), .ack(MEM_ACK));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic load(input logic [15:0] la, input logic [15:0] ly, input logic [7:0] lf);
    @(posedge CLK);
    #1 ACC_IN = la;
    Y_IN = ly;
    FLAGS_IN = lf;
    REG_LOAD = 1'b1;
    @(posedge CLK);
    #1 REG_LOAD = 1'b0;
  endtask
  // issue one request and wait for its completion pulse
  task automatic run(input logic [2:0] op, input logic [15:0] ad, input logic want);
    int k;
    @(posedge CLK);
    #1 START = 1'b1;
    OPCODE = op;
    INDEXED_ADDR = ad;
    @(posedge CLK);
    #1 START = 1'b0;
    chk("busy", {31'h0, BUSY}, {31'h0, op < 3'h4});
    if (op < 3'h4) chk("addr", {16'h0, MEM_ADDR}, {16'h0, ad});
    for (k = 0; k < 40 && DONE !== 1'b1; k++) @(posedge CLK) #1;
    if (want && k == 40) begin
      err_total++;
      wrap_up();
    end
    chk("done", {31'h0, DONE}, {31'h0, want});
  endtask
  initial begin
    RST_B = 1'b0;
    START = 1'b0;
    REG_LOAD = 1'b0;
    OPCODE = 3'h0;
    INDEXED_ADDR = 16'h0000;
    ACC_IN = 16'h0000;
    Y_IN = 16'h0000;
    FLAGS_IN = 8'h00;
    dly = 2'h0;
    repeat (2) @(posedge CLK);
    #1 RST_B = 1'b1;
    chk("flags_rst", {24'h0, CONDITION_FLAGS}, 32'h0000_00D0);
    repeat (2) @(posedge CLK);
    for (i = 0; i < 16; i++) begin
      a = av[i % 4];
      m = mv[i % 4];
      dly = 2'(i % 3);
      f = {i[3:0], 4'hA};
      d = a - m;
      res = ((a < m) ^ (i >= 8)) ? m : a;
      ummu_mem_model_i.mem[i] = m;
      w0 = ummu_mem_model_i.n_wr;
      load(a, 16'h1111, f);
      run(3'(i / 4), 16'(i), 1'b1);
      chk("flags", {24'h0, CONDITION_FLAGS}, {24'h0, f[7:4], d[15], d == 16'h0000,
        (a[15] & ~m[15] & ~d[15]) | (~a[15] & m[15] & d[15]), a < m});
      chk("y_kept", {16'h0, Y_OUT}, 32'h0000_1111);
      if ((i / 4) % 2 == 1) begin
        chk("acc_mem", {16'h0, ACC_OUT}, {16'h0, a});
        chk("mem", {16'h0, ummu_mem_model_i.mem[i]}, {16'h0, res});
        chk("writes", 32'(ummu_mem_model_i.n_wr - w0), 32'h1);
      end else begin
        chk("acc", {16'h0, ACC_OUT}, {16'h0, res});
        chk("writes", 32'(ummu_mem_model_i.n_wr - w0), 32'h0);
      end
    end
    for (i = 0; i < 4; i++) begin
      a = av[i] ^ mv[3 - i];
      m = (i == 1) ? 16'h0000 : mv[i];
      f = i[0] ? 8'h5F : 8'hA0;
      p = {16'h0, a} * {16'h0, m};
      load(a, m, f);
      run(3'h4, 16'h0000, 1'b1);
      chk("product", {Y_OUT, ACC_OUT}, p);
      chk("mul_flags", {24'h0, CONDITION_FLAGS}, {24'h0, f[7:4], p[31], p == 32'h0,
        f[1], p[15]});
    end
    load(16'h4321, 16'h0000, 8'h00);
    run(3'h5, 16'h0000, 1'b0);
    chk("acc_kept", {16'h0, ACC_OUT}, 32'h0000_4321);
    chk("flags_kept", {24'h0, CONDITION_FLAGS}, 32'h0000_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
